// ### hdl/can_transceiver_mode_wake_logic.sv
// Mode control, bus wake-up detection and fail-safe logic of a CAN transceiver
//
// Behaviour
// - Low standby-select with good supplies selects Normal
// - Normal: transmit low drives dominant, high recessive
// - Normal: receive output low dominant, high recessive
// - High standby-select: Standby, transmitter and receiver off
// - Standby: bus biased to ground, never dominant
// - Standby: receive high until wake, then follows
// - Low standby-select in Standby returns to Normal
// - Wake needs dominant, recessive, dominant minimum phases
// - Short intervals between qualifying phases are ignored
// - Pattern not done within time-out resets detector
// - After wake stay Standby, mirror bus on receive
// - Standby: phases below filter time are invisible
// - No wake on Normal, time-out or switch-off undervoltage
// - Transmit low too long disables the transmitter
// - Transmit high clears the dominant timer
// - Floating transmit and standby-select read high
// - Standby undervoltage forces Standby, ignores select
// - Switch-off undervoltage disengages from bus entirely
// - Overtemperature disables drivers until cool and transmit high
`timescale 1ns/1ps
`default_nettype none
`include "can_xcvr_consts.svh"

module can_transceiver_mode_wake_logic #(
	parameter logic [15:0] WAKE_DOM_MIN    = `WAKE_DOM_MIN_TICKS,
	parameter logic [15:0] WAKE_REC_MIN    = `WAKE_REC_MIN_TICKS,
	parameter logic [15:0] WAKE_FILTER     = `WAKE_FILTER_TICKS,
	parameter logic [15:0] WAKE_TIMEOUT    = `WAKE_TIMEOUT_TICKS,
	parameter logic [15:0] TXD_DOM_TIMEOUT = `TXD_DOM_TIMEOUT_TICKS
) (
	input  wire logic                 sys_clk,
	input  wire logic                 sys_rst,
	input  wire logic                 txd_pin,
	input  wire logic                 txd_driven,
	input  wire logic                 stb_pin,
	input  wire logic                 stb_driven,
	input  wire logic                 bus_dominant,
	input  wire logic                 lp_bus_dominant,
	input  wire logic                 main_supply_standby_undervoltage,
	input  wire logic                 io_supply_switchoff_undervoltage,
	input  wire logic                 main_supply_switchoff_undervoltage,
	input  wire logic                 over_temperature,
	input  wire logic                 io_supply_present,
	output var  logic                 rxd,
	output var  logic                 bus_drive_dominant,
	output var  logic                 bus_bias_ground,
	output var  logic                 bus_disengaged,
	output var  logic                 normal_mode,
	output var  logic                 wake_detected,
	output var  logic                 txd_timed_out,
	output var  logic                 thermal_shutdown,
	output var  can_xcvr_pkg::event_t rx_event_data,
	output var  logic                 rx_event_valid,
	input  wire logic                 rx_event_ready,
	output var  logic                 rx_event_accept
);
	import can_xcvr_pkg::*;

	localparam logic [7:0] TICK_LAST = 8'(`TICK_CYCLES - 1);

	// ==========================================================
	// Helpers

	// Saturating increment keeps long phases from wrapping a counter
	function automatic count_t sat_inc(input count_t v);
		sat_inc = (v == 16'hFFFF) ? v : count_t'(v + 16'h0001);
	endfunction : sat_inc

	// ==========================================================
	// Declarations
	logic [`SYN_W-1:0] sync1_q;
	logic [`SYN_W-1:0] sync2_q;
	logic              vio_q;
	logic              strap_taken_q;
	logic [7:0]        tick_cnt_q;
	logic              tick_q;
	logic              txd_eff;
	logic              stb_eff;
	logic              uv_switchoff;
	logic              uv_standby;
	mode_e             mode_q;
	mode_e             mode_d;
	logic              lp_filt_q;
	count_t            filt_cnt_q;
	wake_e             wake_q;
	count_t            run_cnt_q;
	count_t            wake_to_q;
	logic              wake_abort;
	count_t            txd_cnt_q;
	logic              txd_to_q;
	logic              ot_q;
	logic              rxd_d;
	logic              evt_push_q;
	event_t            evt_data_q;
	logic              evt_ready;

	// ==========================================================
	// Input synchronisers

	// Every pin crosses two flops; nothing reads the first stage
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sync1_q <= 11'h000;
			sync2_q <= 11'h000;
		end else begin
			sync1_q <= {io_supply_present, over_temperature,
			            main_supply_switchoff_undervoltage,
			            io_supply_switchoff_undervoltage,
			            main_supply_standby_undervoltage, lp_bus_dominant,
			            bus_dominant, stb_driven, stb_pin, txd_driven, txd_pin};
			sync2_q <= sync1_q;
		end
	end

	// Variant strap caught once, after the synchroniser has settled
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			vio_q         <= 1'b0;
			strap_taken_q <= 1'b0;
		end else if (!strap_taken_q && tick_q) begin
			vio_q         <= sync2_q[`SYN_VIO];
			strap_taken_q <= 1'b1;
		end
	end

	// Undriven inputs read high through the internal pull-ups
	assign txd_eff = sync2_q[`SYN_TXD_DRV] ? sync2_q[`SYN_TXD] : 1'b1;
	assign stb_eff = sync2_q[`SYN_STB_DRV] ? sync2_q[`SYN_STB] : 1'b1;

	// Switch-off level comes from the I/O supply when that pin exists
	assign uv_switchoff = vio_q ? sync2_q[`SYN_UV_IO] : sync2_q[`SYN_UV_MAIN];
	assign uv_standby   = sync2_q[`SYN_UV_STB];

	// ==========================================================
	// Timebase

	// One tick per microsecond; all thresholds count these
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tick_cnt_q <= 8'h00;
			tick_q     <= 1'b0;
		end else if (tick_cnt_q == TICK_LAST) begin
			tick_cnt_q <= 8'h00;
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 8'h01;
			tick_q     <= 1'b0;
		end
	end

	// ==========================================================
	// Mode control

	// Switch-off beats standby undervoltage, which beats the select pin
	always_comb begin
		if (uv_switchoff) begin
			mode_d = MODE_OFF;
		end else if (uv_standby) begin
			mode_d = MODE_STANDBY;
		end else if (stb_eff) begin
			mode_d = MODE_STANDBY;
		end else begin
			mode_d = MODE_NORMAL;
		end
	end

	// Reset lands in Standby, the state a floating select gives
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mode_q <= MODE_STANDBY;
		end else begin
			mode_q <= mode_d;
		end
	end

	// ==========================================================
	// Low-power monitor filter

	// Level must hold for the filter time before the monitor sees it
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			lp_filt_q  <= 1'b0;
			filt_cnt_q <= 16'h0000;
		end else if (sync2_q[`SYN_LP_DOM] == lp_filt_q) begin
			filt_cnt_q <= 16'h0000;
		end else if (tick_q) begin
			if (sat_inc(filt_cnt_q) >= WAKE_FILTER) begin
				lp_filt_q  <= sync2_q[`SYN_LP_DOM];
				filt_cnt_q <= 16'h0000;
			end else begin
				filt_cnt_q <= sat_inc(filt_cnt_q);
			end
		end
	end

	// ==========================================================
	// Wake-up pattern detector

	// Normal mode, time-out or switch-off throws the pattern away
	assign wake_abort = (mode_q != MODE_STANDBY) || uv_switchoff
	                    || (wake_q != WK_IDLE && wake_q != WK_DONE
	                        && wake_to_q >= WAKE_TIMEOUT);

	// Run counter measures the current qualifying phase; a wrong-level
	// glitch only restarts it, so short intervals never fail the pattern
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wake_q    <= WK_IDLE;
			run_cnt_q <= 16'h0000;
		end else if (wake_abort) begin
			wake_q    <= WK_IDLE;
			run_cnt_q <= 16'h0000;
		end else begin
			unique case (wake_q)
				WK_IDLE: begin
					run_cnt_q <= 16'h0000;
					if (lp_filt_q) begin
						wake_q <= WK_DOM1;
					end
				end
				WK_DOM1: begin
					if (!lp_filt_q) begin
						run_cnt_q <= 16'h0000;
					end else if (tick_q) begin
						if (sat_inc(run_cnt_q) >= WAKE_DOM_MIN) begin
							wake_q    <= WK_REC;
							run_cnt_q <= 16'h0000;
						end else begin
							run_cnt_q <= sat_inc(run_cnt_q);
						end
					end
				end
				WK_REC: begin
					if (lp_filt_q) begin
						run_cnt_q <= 16'h0000;
					end else if (tick_q) begin
						if (sat_inc(run_cnt_q) >= WAKE_REC_MIN) begin
							wake_q    <= WK_DOM2;
							run_cnt_q <= 16'h0000;
						end else begin
							run_cnt_q <= sat_inc(run_cnt_q);
						end
					end
				end
				WK_DOM2: begin
					if (!lp_filt_q) begin
						run_cnt_q <= 16'h0000;
					end else if (tick_q) begin
						if (sat_inc(run_cnt_q) >= WAKE_DOM_MIN) begin
							wake_q    <= WK_DONE;
							run_cnt_q <= 16'h0000;
						end else begin
							run_cnt_q <= sat_inc(run_cnt_q);
						end
					end
				end
				WK_DONE: begin
					// Held until Standby is left, by the host or by switch-off undervoltage
					run_cnt_q <= 16'h0000;
				end
				default: begin
					wake_q    <= WK_IDLE;
					run_cnt_q <= 16'h0000;
				end
			endcase
		end
	end

	// Overall pattern timer runs from the first dominant edge
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wake_to_q <= 16'h0000;
		end else if (wake_abort || wake_q == WK_IDLE || wake_q == WK_DONE) begin
			wake_to_q <= 16'h0000;
		end else if (tick_q) begin
			wake_to_q <= sat_inc(wake_to_q);
		end
	end

	// ==========================================================
	// Transmit dominant time-out

	// Timer only runs while transmit is low; high clears it at once
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			txd_cnt_q <= 16'h0000;
			txd_to_q  <= 1'b0;
		end else if (txd_eff) begin
			txd_cnt_q <= 16'h0000;
			txd_to_q  <= 1'b0;
		end else if (tick_q) begin
			txd_cnt_q <= sat_inc(txd_cnt_q);
			if (sat_inc(txd_cnt_q) > TXD_DOM_TIMEOUT) begin
				txd_to_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Thermal shutdown latch

	// Release also waits for transmit high so a hot part cannot oscillate
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ot_q <= 1'b0;
		end else if (sync2_q[`SYN_OT]) begin
			ot_q <= 1'b1;
		end else if (txd_eff) begin
			ot_q <= 1'b0;
		end
	end

	// ==========================================================
	// Bus side outputs

	// Drive only in Normal; Standby and off never drive dominant
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			bus_drive_dominant <= 1'b0;
			bus_bias_ground    <= 1'b1;
			bus_disengaged     <= 1'b0;
		end else begin
			bus_drive_dominant <= (mode_d == MODE_NORMAL) && !txd_eff
			                      && !txd_to_q && !ot_q;
			bus_bias_ground    <= (mode_d == MODE_STANDBY);
			bus_disengaged     <= (mode_d == MODE_OFF);
		end
	end

	// ==========================================================
	// Receive output

	// Standby shows the filtered monitor only once a wake is held
	always_comb begin
		unique case (mode_q)
			MODE_NORMAL:  rxd_d = !sync2_q[`SYN_BUS_DOM];
			MODE_STANDBY: rxd_d = (wake_q == WK_DONE) ? !lp_filt_q : 1'b1;
			MODE_OFF:     rxd_d = 1'b1;
			default:      rxd_d = 1'b1;
		endcase
	end

	// Status outputs registered next to the receive pin
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rxd              <= 1'b1;
			normal_mode      <= 1'b0;
			wake_detected    <= 1'b0;
			txd_timed_out    <= 1'b0;
			thermal_shutdown <= 1'b0;
		end else begin
			rxd              <= rxd_d;
			normal_mode      <= (mode_q == MODE_NORMAL);
			wake_detected    <= (wake_q == WK_DONE);
			txd_timed_out    <= txd_to_q;
			thermal_shutdown <= ot_q;
		end
	end

	// ==========================================================
	// Receive event stream

	// Each change of the receive level is offered as one event; the pin
	// itself cannot wait, so a full buffer shows on rx_event_accept
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			evt_push_q <= 1'b0;
			evt_data_q <= 2'h0;
		end else if (rxd_d != rxd) begin
			evt_push_q <= 1'b1;
			evt_data_q <= {(mode_q == MODE_STANDBY), rxd_d};
		end else if (evt_ready) begin
			evt_push_q <= 1'b0;
		end
	end

	can_rx_event_buffer u_rx_event_buffer (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.in_data   (evt_data_q),
		.in_valid  (evt_push_q),
		.in_ready  (evt_ready),
		.out_data  (rx_event_data),
		.out_valid (rx_event_valid),
		.out_ready (rx_event_ready)
	);

	// Buffer ready mirrored out through a flop
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rx_event_accept <= 1'b1;
		end else begin
			rx_event_accept <= evt_ready;
		end
	end

endmodule : can_transceiver_mode_wake_logic

`default_nettype wire

// ### hdl/can_xcvr_consts.svh
// Constants for the CAN transceiver mode, wake-up and fail-safe logic
`ifndef CAN_XCVR_CONSTS_SVH
`define CAN_XCVR_CONSTS_SVH

// ==========================================================
// Clock and timebase
`define CLK_MHZ              50
`define TICK_NS              1000
`define TICK_CYCLES          ((`TICK_NS * `CLK_MHZ + 999) / 1000)
`define TICK_W               8

// ==========================================================
// Default thresholds, counted in timebase ticks
`define CNT_W                16
`define WAKE_DOM_MIN_TICKS   16'h0005
`define WAKE_REC_MIN_TICKS   16'h0005
`define WAKE_FILTER_TICKS    16'h0001
`define WAKE_TIMEOUT_TICKS   16'h03E8
`define TXD_DOM_TIMEOUT_TICKS 16'h03E8

// ==========================================================
// Input synchroniser bit positions
`define SYN_W                11
`define SYN_TXD              0
`define SYN_TXD_DRV          1
`define SYN_STB              2
`define SYN_STB_DRV          3
`define SYN_BUS_DOM          4
`define SYN_LP_DOM           5
`define SYN_UV_STB           6
`define SYN_UV_IO            7
`define SYN_UV_MAIN          8
`define SYN_OT               9
`define SYN_VIO              10

// ==========================================================
// Receive event buffer
`define EVT_W                2
`define EVT_BIT_LEVEL        0
`define EVT_BIT_STANDBY      1

`endif

// ### hdl/can_xcvr_pkg.sv
// Types for the CAN transceiver mode, wake-up and fail-safe logic
package can_xcvr_pkg;

	// Operating mode, one-hot
	typedef enum logic [2:0] {
		MODE_OFF     = 3'h1,
		MODE_NORMAL  = 3'h2,
		MODE_STANDBY = 3'h4
	} mode_e;

	// Wake-up pattern detector, one-hot
	typedef enum logic [4:0] {
		WK_IDLE = 5'h01,
		WK_DOM1 = 5'h02,
		WK_REC  = 5'h04,
		WK_DOM2 = 5'h08,
		WK_DONE = 5'h10
	} wake_e;

	typedef logic [15:0] count_t;
	typedef logic [1:0]  event_t;

endpackage : can_xcvr_pkg

// ### hdl/can_rx_event_buffer.sv
// Two-entry skid buffer for receive-level change events
`timescale 1ns/1ps
`default_nettype none

module can_rx_event_buffer (
	input  wire logic                 sys_clk,
	input  wire logic                 sys_rst,
	input  wire can_xcvr_pkg::event_t in_data,
	input  wire logic                 in_valid,
	output var  logic                 in_ready,
	output var  can_xcvr_pkg::event_t out_data,
	output var  logic                 out_valid,
	input  wire logic                 out_ready
);
	import can_xcvr_pkg::*;

	event_t skid_q;
	logic   skid_valid_q;
	logic   skid_valid_d;
	logic   push;
	logic   drain;

	// ==========================================================
	// Handshake terms
	assign push  = in_valid & in_ready;
	assign drain = out_ready | ~out_valid;

	// Skid slot fills only when the head is stalled
	always_comb begin
		skid_valid_d = skid_valid_q;
		if (drain) begin
			skid_valid_d = skid_valid_q & push;
		end else if (push) begin
			skid_valid_d = 1'b1;
		end
	end

	// Head and skid storage
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			out_valid    <= 1'b0;
			skid_valid_q <= 1'b0;
			in_ready     <= 1'b1;
			out_data     <= 2'h0;
			skid_q       <= 2'h0;
		end else begin
			skid_valid_q <= skid_valid_d;
			// Ready registered so the source sees full one edge ahead
			in_ready     <= ~skid_valid_d;
			if (drain) begin
				if (skid_valid_q) begin
					out_data  <= skid_q;
					out_valid <= 1'b1;
					if (push) begin
						skid_q <= in_data;
					end
				end else begin
					out_valid <= push;
					if (push) begin
						out_data <= in_data;
					end
				end
			end else if (push) begin
				skid_q <= in_data;
			end
		end
	end

endmodule : can_rx_event_buffer

`default_nettype wire

// ### sim/xcvr_props.sv
// Concurrent assertions on the ports of the transceiver mode and wake logic
`timescale 1ns/1ps
`default_nettype none

module xcvr_props (
	input wire logic                 sys_clk,
	input wire logic                 sys_rst,
	input wire logic                 txd_pin,
	input wire logic                 txd_driven,
	input wire logic                 stb_pin,
	input wire logic                 stb_driven,
	input wire logic                 main_supply_standby_undervoltage,
	input wire logic                 io_supply_switchoff_undervoltage,
	input wire logic                 main_supply_switchoff_undervoltage,
	input wire logic                 rxd,
	input wire logic                 bus_drive_dominant,
	input wire logic                 bus_bias_ground,
	input wire logic                 bus_disengaged,
	input wire logic                 normal_mode,
	input wire logic                 wake_detected,
	input wire logic                 txd_timed_out,
	input wire logic                 thermal_shutdown,
	input wire can_xcvr_pkg::event_t rx_event_data,
	input wire logic                 rx_event_valid,
	input wire logic                 rx_event_ready
);
	import can_xcvr_pkg::*;

	// ==========================================================
	// Helpers
	// Pin levels after the pull-ups; a floating pin reads high
	wire logic stb_high = stb_pin || !stb_driven;
	wire logic txd_high = txd_pin || !txd_driven;
	wire logic supplies_ok = !(main_supply_standby_undervoltage
		|| io_supply_switchoff_undervoltage || main_supply_switchoff_undervoltage);

	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	// ==========================================================
	// Properties
	// Runs of eight cycles cover the two-flop synchroniser plus mode latency
	property p_sel_normal;
		(!stb_high && supplies_ok)[*8] |-> normal_mode;
	endproperty
	a_sel_normal: assert property (p_sel_normal) else $error("normal mode not entered");
	property p_sel_standby;
		stb_high[*8] |-> !normal_mode;
	endproperty
	a_sel_standby: assert property (p_sel_standby) else $error("standby not kept");
	property p_uv_standby;
		main_supply_standby_undervoltage[*8] |-> !normal_mode;
	endproperty
	a_uv_standby: assert property (p_uv_standby) else $error("undervoltage ignored");
	property p_drive_mode;
		bus_drive_dominant |-> !bus_bias_ground && !bus_disengaged;
	endproperty
	a_drive_mode: assert property (p_drive_mode) else $error("dominant outside normal");
	property p_tx_recessive;
		txd_high[*4] |-> !bus_drive_dominant;
	endproperty
	a_tx_recessive: assert property (p_tx_recessive) else $error("dominant with txd high");
	property p_timeout_off;
		txd_timed_out[*2] |-> !bus_drive_dominant;
	endproperty
	a_timeout_off: assert property (p_timeout_off) else $error("driver on after time-out");
	property p_timeout_clear;
		txd_high[*5] |-> !txd_timed_out;
	endproperty
	a_timeout_clear: assert property (p_timeout_clear) else $error("time-out not cleared");
	property p_thermal_off;
		thermal_shutdown[*2] |-> !bus_drive_dominant;
	endproperty
	a_thermal_off: assert property (p_thermal_off) else $error("driver on while hot");
	property p_rxd_idle;
		(stb_high && !normal_mode && !wake_detected)[*6] |-> rxd;
	endproperty
	a_rxd_idle: assert property (p_rxd_idle) else $error("rxd low before wake");
	property p_wake_standby;
		normal_mode[*2] |-> !wake_detected;
	endproperty
	a_wake_standby: assert property (p_wake_standby) else $error("wake held in normal");
	property p_evt_hold;
		rx_event_valid && !rx_event_ready |=> rx_event_valid && $stable(rx_event_data);
	endproperty
	a_evt_hold: assert property (p_evt_hold) else $error("event dropped while stalled");

endmodule : xcvr_props

bind can_transceiver_mode_wake_logic xcvr_props xcvr_props_inst (.*);

`default_nettype wire

// ### sim/host_ctrl_model.sv
// Host controller model: sinks the receive event stream and can stall it
`timescale 1ns/1ps
`default_nettype none
`include "can_xcvr_consts.svh"

module host_ctrl_model (
	input  wire logic                 sys_clk,
	input  wire logic                 sys_rst,
	input  wire can_xcvr_pkg::event_t rx_event_data,
	input  wire logic                 rx_event_valid,
	input  wire logic                 stall,
	output var  logic                 rx_event_ready,
	output var  logic                 last_level
);
	import can_xcvr_pkg::*;

	// ==========================================================
	// Sink
	// Ready follows the stall request one edge late, as a busy host would
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rx_event_ready <= 1'b0;
			last_level     <= 1'b1;
		end else begin
			rx_event_ready <= !stall;
			if (rx_event_valid && rx_event_ready) begin
				last_level <= rx_event_data[`EVT_BIT_LEVEL];
			end
		end
	end

endmodule : host_ctrl_model

`default_nettype wire

// ### sim/tb_top.sv
// Self-checking testbench for the transceiver mode, wake and fail-safe logic
`timescale 1ns/1ps
`default_nettype none
`include "can_xcvr_consts.svh"

module tb_top;
	import can_xcvr_pkg::*;

	localparam int TK = `TICK_CYCLES;
	logic   sys_clk, sys_rst, txd_pin, txd_driven, stb_pin, stb_driven, bus_dominant;
	logic   lp_bus_dominant, main_supply_standby_undervoltage, over_temperature;
	logic   io_supply_switchoff_undervoltage, main_supply_switchoff_undervoltage;
	logic   io_supply_present, rxd, bus_drive_dominant, bus_bias_ground, bus_disengaged;
	logic   normal_mode, wake_detected, txd_timed_out, thermal_shutdown, stall, last_level;
	logic   rx_event_valid, rx_event_ready, rx_event_accept;
	event_t rx_event_data;
	int     bad_count, samples_checked, cycles;

	// ==========================================================
	// Design and host model
	// Short thresholds; filter of two ticks so a sub-tick glitch never qualifies
	can_transceiver_mode_wake_logic #(.WAKE_DOM_MIN(16'h0003), .WAKE_REC_MIN(16'h0003),
		.WAKE_FILTER(16'h0002), .WAKE_TIMEOUT(16'h0028), .TXD_DOM_TIMEOUT(16'h0014))
	can_transceiver_mode_wake_logic_inst (.sys_clk, .sys_rst, .txd_pin, .txd_driven, .stb_pin,
		.stb_driven, .bus_dominant, .lp_bus_dominant, .main_supply_standby_undervoltage,
		.io_supply_switchoff_undervoltage, .main_supply_switchoff_undervoltage,
		.over_temperature, .io_supply_present, .rxd, .bus_drive_dominant, .bus_bias_ground,
		.bus_disengaged, .normal_mode, .wake_detected, .txd_timed_out, .thermal_shutdown,
		.rx_event_data, .rx_event_valid, .rx_event_ready, .rx_event_accept);
	host_ctrl_model host_ctrl_model_inst (.sys_clk, .sys_rst, .rx_event_data,
		.rx_event_valid, .stall, .rx_event_ready, .last_level);

	// ==========================================================
	// Clock and watchdog
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			test_done();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	task automatic check_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %b, expected %b", $time, got, exp);
		end
	endtask : check_bit
	task automatic phase(input logic dom, input int ticks);
		@(posedge sys_clk);
		lp_bus_dominant <= dom;
		cyc(ticks * TK);
	endtask : phase
	task automatic test_done();
		$display("checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done

	// ==========================================================
	// Scenarios
	task automatic t_normal();
		@(posedge sys_clk);
		stb_pin <= 1'b0;
		cyc(10);
		check_bit(normal_mode, 1'b1);
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			txd_pin      <= i[0];
			bus_dominant <= !i[1];
			cyc(8);
			check_bit(bus_drive_dominant, !i[0]);
			check_bit(rxd, i[1]);
		end
	endtask : t_normal

	task automatic t_standby();
		@(posedge sys_clk);
		stb_pin      <= 1'b1;
		txd_pin      <= 1'b0;
		bus_dominant <= 1'b1;
		cyc(10);
		check_bit(normal_mode, 1'b0);
		check_bit(bus_drive_dominant, 1'b0);
		check_bit(bus_bias_ground, 1'b1);
		check_bit(rxd, 1'b1);
		@(posedge sys_clk);
		txd_pin      <= 1'b1;
		stb_pin      <= 1'b0;
		stb_driven   <= 1'b0;
		bus_dominant <= 1'b0;
		cyc(10);
		check_bit(normal_mode, 1'b0);
		@(posedge sys_clk);
		stb_pin    <= 1'b1;
		stb_driven <= 1'b1;
	endtask : t_standby

	task automatic t_supply();
		@(posedge sys_clk);
		stb_pin                          <= 1'b0;
		main_supply_standby_undervoltage <= 1'b1;
		cyc(10);
		check_bit(normal_mode, 1'b0);
		@(posedge sys_clk);
		main_supply_standby_undervoltage <= 1'b0;
		io_supply_switchoff_undervoltage <= 1'b1;
		cyc(10);
		check_bit(bus_disengaged, 1'b1);
		check_bit(bus_drive_dominant, 1'b0);
		@(posedge sys_clk);
		io_supply_switchoff_undervoltage   <= 1'b0;
		main_supply_switchoff_undervoltage <= 1'b1; // Ignored while strap picks I/O
		stb_pin                            <= 1'b1;
		cyc(10);
		check_bit(bus_disengaged, 1'b0);
		main_supply_switchoff_undervoltage <= 1'b0;
		// Switch-off in mid-pattern must throw the half-seen pattern away
		phase(1'b1, 6);
		phase(1'b0, 6);
		@(posedge sys_clk);
		io_supply_switchoff_undervoltage <= 1'b1;
		cyc(10);
		@(posedge sys_clk);
		io_supply_switchoff_undervoltage <= 1'b0;
		phase(1'b1, 6);
		check_bit(wake_detected, 1'b0);
	endtask : t_supply

	task automatic t_wake();
		phase(1'b1, 6);
		phase(1'b0, 45);
		check_bit(wake_detected, 1'b0);
		phase(1'b1, 6);
		check_bit(wake_detected, 1'b0);
		// Short runs inside the pattern must not spoil it
		phase(1'b0, 2);
		phase(1'b1, 2);
		phase(1'b0, 6);
		phase(1'b1, 6);
		check_bit(wake_detected, 1'b1);
		check_bit(rxd, 1'b0);
		check_bit(normal_mode, 1'b0);
		phase(1'b0, 4);
		check_bit(rxd, 1'b1);
		@(posedge sys_clk);
		lp_bus_dominant <= 1'b1;
		repeat (20) begin
			@(posedge sys_clk);
			check_bit(rxd, 1'b1);
		end
		lp_bus_dominant <= 1'b0;
		cyc(3 * TK);
		check_bit(rxd, 1'b1);
		@(posedge sys_clk);
		stb_pin <= 1'b0;
		cyc(10);
		check_bit(normal_mode, 1'b1);
		check_bit(wake_detected, 1'b0);
	endtask : t_wake

	task automatic t_txd_guard();
		@(posedge sys_clk);
		txd_pin <= 1'b0;
		cyc(19 * TK);
		check_bit(bus_drive_dominant, 1'b1);
		cyc(3 * TK);
		check_bit(txd_timed_out, 1'b1);
		check_bit(bus_drive_dominant, 1'b0);
		@(posedge sys_clk);
		txd_pin <= 1'b1;
		cyc(10);
		check_bit(txd_timed_out, 1'b0);
		@(posedge sys_clk);
		txd_pin          <= 1'b0;
		over_temperature <= 1'b1;
		cyc(10);
		check_bit(bus_drive_dominant, 1'b0);
		@(posedge sys_clk);
		over_temperature <= 1'b0;
		cyc(10);
		check_bit(thermal_shutdown, 1'b1);
		@(posedge sys_clk);
		txd_pin <= 1'b1;
		cyc(10);
		check_bit(thermal_shutdown, 1'b0);
		@(posedge sys_clk);
		txd_pin <= 1'b0;
		cyc(10);
		check_bit(bus_drive_dominant, 1'b1);
		@(posedge sys_clk);
		txd_driven <= 1'b0;
		cyc(10);
		check_bit(bus_drive_dominant, 1'b0);
		txd_pin    <= 1'b1;
		txd_driven <= 1'b1;
	endtask : t_txd_guard

	task automatic t_events();
		@(posedge sys_clk);
		stall <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			@(posedge sys_clk);
			bus_dominant <= !i[0];
			cyc(10);
		end
		check_bit(rx_event_valid, 1'b1);
		check_bit(rx_event_data[`EVT_BIT_LEVEL], 1'b0);
		check_bit(rx_event_accept, 1'b0);
		@(posedge sys_clk);
		stall <= 1'b0;
		cyc(10);
		check_bit(rx_event_valid, 1'b0);
		check_bit(rx_event_accept, 1'b1);
		check_bit(last_level, 1'b0);
	endtask : t_events

	// ==========================================================
	// Main sequence
	initial begin
		{txd_pin, txd_driven, stb_pin, stb_driven, io_supply_present, sys_rst} = 6'h3F;
		{bus_dominant, lp_bus_dominant, over_temperature, stall} = 4'h0;
		{main_supply_standby_undervoltage, io_supply_switchoff_undervoltage} = 2'h0;
		main_supply_switchoff_undervoltage = 1'b0;
		{bad_count, samples_checked, cycles} = '0;
		cyc(10);
		sys_rst <= 1'b0;
		cyc(2 * TK);
		t_normal();
		t_standby();
		t_supply();
		t_wake();
		t_txd_guard();
		t_events();
		test_done();
	end

endmodule : tb_top

`default_nettype wire
